// file: include/fsc_pkg.sv
package fsc_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NUM_CH = 8;
    localparam int SIG_W = 4;
    localparam int CNT_W = 7;

    // The channel number sits in the top nibble of the address.
    localparam int CH_MSB = 15;
    localparam int CH_LSB = 12;
    localparam logic [11:0] FSEL_OFFSET = 12'h107;
    localparam logic [11:0] STAT_OFFSET = 12'h108;

    localparam logic [DATA_W-1:0] FSEL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STAT_RESET = 8'h00;

    localparam int SIG_BND_BIT = 7;
    localparam int FORCE_CRC_BIT = 6;
    localparam int JAPAN_BIT = 5;
    localparam int SINGLE_CAND_BIT = 4;
    localparam int QUICK_SYNC_BIT = 3;
    localparam int FMT_MSB = 2;
    localparam int FMT_LSB = 0;

    localparam int STAT_SYNC_BIT = 0;
    localparam int STAT_MATCH_BIT = 1;
    localparam int STAT_SIG_LSB = 4;

    localparam logic [CNT_W-1:0] SYNC_ESF = 7'h60;
    localparam logic [CNT_W-1:0] SYNC_ESF_FAST = 7'h30;
    localparam logic [CNT_W-1:0] SYNC_SF = 7'h30;
    localparam logic [CNT_W-1:0] SYNC_SF_FAST = 7'h18;

    typedef enum {FMT_ESF, FMT_SF, FMT_N, FMT_DM, FMT_SLC} fsc_fmt_e;

    typedef struct packed {
        logic sf_boundary;
        logic rx_sig_valid;
        logic [SIG_W-1:0] rx_sig;
        logic tx_sig_valid;
        logic [SIG_W-1:0] tx_sig;
        logic fe_bit;
        logic frame_tick;
        logic fbit_ok;
        logic cand_done;
        logic [1:0] cand_cnt;
    } fsc_evt_s;

    typedef struct packed {
        logic [2:0] fmt;
        logic japan;
        logic force_crc;
        logic crc_fe_bit;
        logic yel_j1_sf;
        logic yel_j1_esf;
        logic [SIG_W-1:0] rx_sig_out;
        logic [SIG_W-1:0] tx_sig_out;
        logic sync;
        logic match_ok;
        logic reframe;
    } fsc_cfg_s;

    function automatic fsc_fmt_e fmt_decode(input logic [2:0] f);
        if (!f[2]) begin
            return FMT_ESF;
        end
        case (f[1:0])
            2'h1: return FMT_SF;
            2'h2: return FMT_N;
            2'h3: return FMT_DM;
            default: return FMT_SLC;
        endcase
    endfunction

endpackage

// file: core/fsc_sync_cnt.sv
`timescale 1ns/1ps
module fsc_sync_cnt (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reframe,
    input wire logic i_frame_tick,
    input wire logic i_fbit_ok,
    input wire logic [fsc_pkg::CNT_W-1:0] i_target,
    output logic o_sync
);
    import fsc_pkg::*;

    logic [CNT_W-1:0] cnt_q;

    // A bad F-bit before lock restarts the run of good frames.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_reframe) begin
            cnt_q <= '0;
        end else if (i_frame_tick && !o_sync) begin
            if (!i_fbit_ok) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 7'h01;
            end
        end
    end

    // Lock holds until the next reframe.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_reframe) begin
            o_sync <= 1'b0;
        end else if (i_frame_tick && i_fbit_ok && !o_sync) begin
            o_sync <= (cnt_q + 7'h01) >= i_target;
        end
    end

endmodule

// file: core/fsc_framing_select.sv
`timescale 1ns/1ps
// Functional notes
// - Receive signaling updates at superframe edge if set.
// - Transmit signaling change deferred to superframe edge if set.
// - Force bit inverts outgoing CRC.
// - J1 CRC uses real Fe bit values.
// - T1 CRC treats every Fe bit as one.
// - J1 selects J1 yellow alarm format.
// - J1 variant from J1 bit and format.
// - Several candidates: any winner may be taken.
// - Single-candidate mode needs exactly one left.
// - Sync after 96/48 ESF, 48/24 SF frames.
// - Format field decodes ESF, SF, N, DM, SLC.
// - Format change forces a receive reframe.
module fsc_framing_select (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [fsc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [fsc_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [fsc_pkg::DATA_W-1:0] O_RDATA,
    input wire fsc_pkg::fsc_evt_s [fsc_pkg::NUM_CH-1:0] I_EVT,
    output fsc_pkg::fsc_cfg_s [fsc_pkg::NUM_CH-1:0] O_CFG
);
    import fsc_pkg::*;

    logic [DATA_W-1:0] fsel_q [NUM_CH];
    logic [DATA_W-1:0] stat_w [NUM_CH];
    logic [NUM_CH-1:0] reframe_q;
    logic [NUM_CH-1:0] force_crc_q;
    logic [NUM_CH-1:0] crc_fe_q;
    logic [NUM_CH-1:0] japan_q;
    logic [NUM_CH-1:0] yel_sf_q;
    logic [NUM_CH-1:0] yel_esf_q;
    logic [NUM_CH-1:0] match_q;
    logic [NUM_CH-1:0] sync_w;
    logic [NUM_CH-1:0] rx_pend_q;
    logic [NUM_CH-1:0] tx_pend_q;
    logic [SIG_W-1:0] rx_hold_q [NUM_CH];
    logic [SIG_W-1:0] rx_out_q [NUM_CH];
    logic [SIG_W-1:0] tx_hold_q [NUM_CH];
    logic [SIG_W-1:0] tx_out_q [NUM_CH];
    logic [CNT_W-1:0] target_w [NUM_CH];
    logic [DATA_W-1:0] rdata_d;

    // Offset match ignores the channel nibble; the caller checks it.
    function automatic logic reg_hit(
        input logic [ADDR_W-1:0] a,
        input logic [11:0] off
    );
        return a[CH_LSB-1:0] == off;
    endfunction

    function automatic logic [CNT_W-1:0] sync_target(
        input fsc_fmt_e f,
        input logic fast
    );
        if (f == FMT_ESF) begin
            return fast ? SYNC_ESF_FAST : SYNC_ESF;
        end
        return fast ? SYNC_SF_FAST : SYNC_SF;
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic wr_hit;
            logic fmt_change;
            logic bnd_mode;
            fsc_fmt_e fmt_now;
            fsc_fmt_e fmt_new;

            assign wr_hit = I_WR && reg_hit(I_ADDR, FSEL_OFFSET)
                && (I_ADDR[CH_MSB:CH_LSB] == 4'(ch));
            assign fmt_now = fmt_decode(fsel_q[ch][FMT_MSB:FMT_LSB]);
            assign fmt_new = fmt_decode(I_WDATA[FMT_MSB:FMT_LSB]);
            assign fmt_change = wr_hit && (fmt_new != fmt_now);
            assign bnd_mode = fsel_q[ch][SIG_BND_BIT];
            assign target_w[ch] = sync_target(fmt_now,
                fsel_q[ch][QUICK_SYNC_BIT]);

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    fsel_q[ch] <= FSEL_RESET;
                end else if (wr_hit) begin
                    fsel_q[ch] <= I_WDATA;
                end
            end

            // The pulse follows the write, so the framer restarts
            // hunting under the new format, never the old one.
            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    reframe_q[ch] <= 1'b0;
                end else begin
                    reframe_q[ch] <= fmt_change;
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    force_crc_q[ch] <= 1'b0;
                end else begin
                    force_crc_q[ch] <= fsel_q[ch][FORCE_CRC_BIT];
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    crc_fe_q[ch] <= 1'b1;
                end else if (fsel_q[ch][JAPAN_BIT]) begin
                    crc_fe_q[ch] <= I_EVT[ch].fe_bit;
                end else begin
                    crc_fe_q[ch] <= 1'b1;
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    japan_q[ch] <= 1'b0;
                    yel_sf_q[ch] <= 1'b0;
                    yel_esf_q[ch] <= 1'b0;
                end else begin
                    japan_q[ch] <= fsel_q[ch][JAPAN_BIT];
                    yel_sf_q[ch] <= fsel_q[ch][JAPAN_BIT]
                        && (fmt_now == FMT_SF);
                    yel_esf_q[ch] <= fsel_q[ch][JAPAN_BIT]
                        && (fmt_now == FMT_ESF);
                end
            end

            // Only the latest value waiting for a boundary is kept.
            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    rx_hold_q[ch] <= '0;
                end else if (I_EVT[ch].rx_sig_valid) begin
                    rx_hold_q[ch] <= I_EVT[ch].rx_sig;
                end
            end

            // New data in the boundary cycle wins over the clear.
            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST || !bnd_mode) begin
                    rx_pend_q[ch] <= 1'b0;
                end else if (I_EVT[ch].rx_sig_valid) begin
                    rx_pend_q[ch] <= 1'b1;
                end else if (I_EVT[ch].sf_boundary) begin
                    rx_pend_q[ch] <= 1'b0;
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    rx_out_q[ch] <= '0;
                end else if (!bnd_mode) begin
                    if (I_EVT[ch].rx_sig_valid) begin
                        rx_out_q[ch] <= I_EVT[ch].rx_sig;
                    end
                end else if (I_EVT[ch].sf_boundary) begin
                    if (I_EVT[ch].rx_sig_valid) begin
                        rx_out_q[ch] <= I_EVT[ch].rx_sig;
                    end else if (rx_pend_q[ch]) begin
                        rx_out_q[ch] <= rx_hold_q[ch];
                    end
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    tx_hold_q[ch] <= '0;
                end else if (I_EVT[ch].tx_sig_valid) begin
                    tx_hold_q[ch] <= I_EVT[ch].tx_sig;
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST || !bnd_mode) begin
                    tx_pend_q[ch] <= 1'b0;
                end else if (I_EVT[ch].tx_sig_valid) begin
                    tx_pend_q[ch] <= 1'b1;
                end else if (I_EVT[ch].sf_boundary) begin
                    tx_pend_q[ch] <= 1'b0;
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST) begin
                    tx_out_q[ch] <= '0;
                end else if (!bnd_mode) begin
                    if (I_EVT[ch].tx_sig_valid) begin
                        tx_out_q[ch] <= I_EVT[ch].tx_sig;
                    end
                end else if (I_EVT[ch].sf_boundary) begin
                    if (I_EVT[ch].tx_sig_valid) begin
                        tx_out_q[ch] <= I_EVT[ch].tx_sig;
                    end else if (tx_pend_q[ch]) begin
                        tx_out_q[ch] <= tx_hold_q[ch];
                    end
                end
            end

            // The verdict stands until the next hunt window closes or a reframe pulse clears it.
            always_ff @(posedge I_CLK) begin
                if (I_SYS_RST || reframe_q[ch]) begin
                    match_q[ch] <= 1'b0;
                end else if (I_EVT[ch].cand_done) begin
                    if (fsel_q[ch][SINGLE_CAND_BIT]) begin
                        match_q[ch] <= I_EVT[ch].cand_cnt == 2'h1;
                    end else begin
                        match_q[ch] <= I_EVT[ch].cand_cnt != 2'h0;
                    end
                end
            end

            fsc_sync_cnt u_sync (
                .i_clk(I_CLK),
                .i_rst(I_SYS_RST),
                .i_reframe(reframe_q[ch]),
                .i_frame_tick(I_EVT[ch].frame_tick),
                .i_fbit_ok(I_EVT[ch].fbit_ok),
                .i_target(target_w[ch]),
                .o_sync(sync_w[ch])
            );

            always_comb begin
                stat_w[ch] = STAT_RESET;
                stat_w[ch][STAT_SYNC_BIT] = sync_w[ch];
                stat_w[ch][STAT_MATCH_BIT] = match_q[ch];
                stat_w[ch][STAT_SIG_LSB +: SIG_W] = rx_out_q[ch];
            end

            always_comb begin
                O_CFG[ch].fmt = fsel_q[ch][FMT_MSB:FMT_LSB];
                O_CFG[ch].japan = japan_q[ch];
                O_CFG[ch].force_crc = force_crc_q[ch];
                O_CFG[ch].crc_fe_bit = crc_fe_q[ch];
                O_CFG[ch].yel_j1_sf = yel_sf_q[ch];
                O_CFG[ch].yel_j1_esf = yel_esf_q[ch];
                O_CFG[ch].rx_sig_out = rx_out_q[ch];
                O_CFG[ch].tx_sig_out = tx_out_q[ch];
                O_CFG[ch].sync = sync_w[ch];
                O_CFG[ch].match_ok = match_q[ch];
                O_CFG[ch].reframe = reframe_q[ch];
            end
        end
    endgenerate

    // Channel nibbles above seven and unknown offsets read as zero.
    always_comb begin
        rdata_d = '0;
        if (I_ADDR[CH_MSB] == 1'b0) begin
            if (reg_hit(I_ADDR, FSEL_OFFSET)) begin
                rdata_d = fsel_q[I_ADDR[CH_LSB+2:CH_LSB]];
            end else if (reg_hit(I_ADDR, STAT_OFFSET)) begin
                rdata_d = stat_w[I_ADDR[CH_LSB+2:CH_LSB]];
            end
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            O_RDATA <= rdata_d;
        end else begin
            O_RDATA <= '0;
        end
    end

endmodule

// file: tb/fsc_framing_select_checker.sv
`timescale 1ns/1ps
module fsc_framing_select_checker (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [fsc_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [fsc_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [fsc_pkg::DATA_W-1:0] O_RDATA,
    input wire fsc_pkg::fsc_evt_s [fsc_pkg::NUM_CH-1:0] I_EVT,
    input wire fsc_pkg::fsc_cfg_s [fsc_pkg::NUM_CH-1:0] O_CFG
);
    import fsc_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // Channel zero stands for all eight copies to keep the checker small.
    wire fsc_evt_s e = I_EVT[0];
    wire fsc_cfg_s c = O_CFG[0];
    wire logic good = e.frame_tick & e.fbit_ok;
    property p_rd_idle; !I_RD |=> O_RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside slot");
    property p_t1_fe; !c.japan && !$past(c.japan) |-> c.crc_fe_bit; endproperty
    a_t1_fe: assert property (p_t1_fe)
        else $error("fe not one in T1");
    property p_j1_fe; c.japan && $past(c.japan) |-> c.crc_fe_bit == $past(e.fe_bit); endproperty
    a_j1_fe: assert property (p_j1_fe)
        else $error("fe not real in J1");
    property p_yel_t1; !c.japan |-> !c.yel_j1_sf && !c.yel_j1_esf; endproperty
    a_yel_t1: assert property (p_yel_t1)
        else $error("J1 yellow in T1");
    property p_rx_cause;
        $changed(c.rx_sig_out) |-> $past(e.rx_sig_valid) || $past(e.sf_boundary);
    endproperty
    a_rx_cause: assert property (p_rx_cause)
        else $error("rx signaling moved alone");
    property p_tx_cause;
        $changed(c.tx_sig_out) |-> $past(e.tx_sig_valid) || $past(e.sf_boundary);
    endproperty
    a_tx_cause: assert property (p_tx_cause)
        else $error("tx signaling moved alone");
    property p_crc_force; $changed(c.force_crc) |-> $past(I_WR, 2); endproperty
    a_crc_force: assert property (p_crc_force)
        else $error("force bit moved without write");
    property p_reframe; c.reframe |-> ($past(I_WR) || $past(I_WR, 2)) ##1 !c.reframe; endproperty
    a_reframe: assert property (p_reframe)
        else $error("bad reframe pulse");
    property p_sync_rise; $rose(c.sync) |-> $past(good) || $past(good, 2); endproperty
    a_sync_rise: assert property (p_sync_rise)
        else $error("sync rose without tick");
    property p_match;
        $rose(c.match_ok) |-> $past(e.cand_done) && $past(e.cand_cnt) != 2'h0;
    endproperty
    a_match: assert property (p_match)
        else $error("match without candidate");
endmodule

bind fsc_framing_select fsc_framing_select_checker u_chk (.I_CLK(I_CLK),
    .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_EVT(I_EVT), .O_CFG(O_CFG));

// file: tb/fsc_framer_model.sv
`timescale 1ns/1ps
module fsc_framer_model (
    input wire logic i_clk,
    output fsc_pkg::fsc_evt_s [fsc_pkg::NUM_CH-1:0] o_evt
);
    import fsc_pkg::*;
    initial o_evt = '0;
    // Kinds: 0 signaling, 1 boundary, 2 frame tick, 3 hunt done, 4 Fe level.
    // Signaling and candidate-count fields are inverted once the strobe drops, so stale sampling shows up.
    task automatic send(input int k, input logic [3:0] d);
        fsc_evt_s v;
        v = '0;
        v.fe_bit = (k == 4) ? d[0] : o_evt[0].fe_bit;
        v.rx_sig = d;
        v.tx_sig = d;
        v.cand_cnt = d[1:0];
        v.fbit_ok = d[0];
        v.rx_sig_valid = (k == 0);
        v.tx_sig_valid = (k == 0);
        v.sf_boundary = (k == 1);
        v.frame_tick = (k == 2);
        v.cand_done = (k == 3);
        @(posedge i_clk);
        o_evt[0] <= v;
        {v.rx_sig_valid, v.tx_sig_valid, v.sf_boundary, v.frame_tick, v.cand_done} = '0;
        v.rx_sig = ~d;
        v.tx_sig = ~d;
        v.cand_cnt = ~d[1:0];
        @(posedge i_clk);
        o_evt[0] <= v;
    endtask
endmodule

// file: tb/t1_framing_select_control_test.sv
`timescale 1ns/1ps
module t1_framing_select_control_test;
    import fsc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    fsc_evt_s [NUM_CH-1:0] evt;
    fsc_cfg_s [NUM_CH-1:0] cfg;
    int fail_count = 0;
    int compares = 0;
    int rf = 0;
    logic [7:0] fv [6] = '{8'h05, 8'h08, 8'h0E, 8'h04, 8'h0F, 8'h00};
    int tg [6] = '{48, 48, 24, 48, 24, 96};
    initial forever #25 clk = ~clk;
    fsc_framing_select u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EVT(evt), .O_CFG(cfg));
    fsc_framer_model u_fr (.i_clk(clk), .o_evt(evt));
    always @(posedge clk) if (cfg[0].reframe === 1'b1) rf <= rf + 1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_r(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_r(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, x);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic conclude();
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end
    initial begin
        reset_dut();
        for (int c = 0; c < 8; c++) rd_r({c[3:0], FSEL_OFFSET}, 8'h00);
        for (int c = 0; c < 8; c++) wr_r({c[3:0], FSEL_OFFSET}, {c[3:0], 4'h8});
        for (int c = 0; c < 8; c++) rd_r({c[3:0], FSEL_OFFSET}, {c[3:0], 4'h8});
        wr_r(16'h8107, 8'hFF);
        rd_r(16'h8107, 8'h00);
        rd_r(16'h0100, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr_r(16'h0107, fv[i]);
            wt(1);
            chk(cfg[0].fmt, fv[i][2:0]);
            wt(2);
            chk(cfg[0].sync, 1'b0);
            repeat (5) u_fr.send(2, 4'h1);
            u_fr.send(2, 4'h0);
            repeat (tg[i] - 1) u_fr.send(2, 4'h1);
            wt(2);
            chk(cfg[0].sync, 1'b0);
            u_fr.send(2, 4'h1);
            wt(2);
            chk(cfg[0].sync, 1'b1);
        end
        chk(8'(rf), 8'h06);
        u_fr.send(0, 4'h5);
        wt(1);
        chk(cfg[0].rx_sig_out, 4'h5);
        chk(cfg[0].tx_sig_out, 4'h5);
        wr_r(16'h0107, 8'h80);
        wt(1);
        u_fr.send(0, 4'hA);
        wt(3);
        chk(cfg[0].rx_sig_out, 4'h5);
        chk(cfg[0].tx_sig_out, 4'h5);
        u_fr.send(1, 4'h0);
        wt(1);
        chk(cfg[0].rx_sig_out, 4'hA);
        chk(cfg[0].tx_sig_out, 4'hA);
        rd_r(16'h0108, 8'hA1);
        u_fr.send(4, 4'h0);
        wr_r(16'h0107, 8'h40);
        wt(1);
        chk(cfg[0].force_crc, 1'b1);
        chk(cfg[0].crc_fe_bit, 1'b1);
        wr_r(16'h0107, 8'h20);
        wt(2);
        chk(cfg[0].force_crc, 1'b0);
        chk(cfg[0].crc_fe_bit, 1'b0);
        chk(cfg[0].yel_j1_esf, 1'b1);
        chk(cfg[0].japan, 1'h1);
        wr_r(16'h0107, 8'h25);
        wt(1);
        chk({cfg[0].yel_j1_sf, cfg[0].yel_j1_esf}, 2'h2);
        u_fr.send(3, 4'h2);
        wt(2);
        chk(cfg[0].match_ok, 1'b1);
        wr_r(16'h0107, 8'h10);
        wt(3);
        chk(cfg[0].match_ok, 1'b0);
        chk(8'(rf), 8'h08);
        chk(cfg[0].japan, 1'h0);
        u_fr.send(3, 4'h2);
        wt(2);
        chk(cfg[0].match_ok, 1'b0);
        u_fr.send(3, 4'h1);
        wt(2);
        chk(cfg[0].match_ok, 1'b1);
        reset_dut();
        rd_r(16'h3107, 8'h00);
        chk(cfg[0].match_ok, 1'b0);
        conclude();
    end
endmodule
